// ==== src/bus_arbiter.sv ====
// external bus mastership arbiter for one processor of a cluster
// assumes peers, host and pull-ups on the shared lines sit outside;
// open-drain lines resolve to low when any enabled driver outputs low
//
// Function
// R1: drive only own request line; watch all other request lines
// R2: identity code n selects request line n, 000 to 111
// R3: ordering position among processors comes from identity
// R4: identity straps stay constant except during reset
// R5: absent processors' request lines are held high by the system
// R6: current owner asserts master indicator, for debug only
// R7: master and lock pins are sampled as straps during reset; code samples them on the first enabled edge after reset release
// R8: lock indicator shows the master has locked the bus
// R9: host may assert back-off to break a crossed-read deadlock
// R10: back-off releases the bus at once, dropping the transaction
// R11: host holds its request as long as it needs the bus
// R12: on host request finish transaction, release bus, then grant
// R13: bus pins float while the host owns the bus
// R14: sdram enters self-refresh before the host is granted
// R15: grant stays asserted until host drops its request
// R16: only the master drives host grant; slaves monitor it
// R17: core-priority line asserted during own core external access
// R18: master yields dma when a slave asserts core-priority
// R19: dma-priority line asserted during own high-priority dma access
// R20: normal dma master yields when a slave asserts dma-priority
// R21: simultaneous requesters resolved by identity-ordered round robin; code only takes the bus when no other request line is low
`timescale 1ns/100ps
module bus_arbiter
	import arb_pkg::*;
(
	input  wire logic              mclk_i,
	input  wire logic              rst_n_i,
	input  wire logic              clk_en_i,
	input  wire logic [ID_W-1:0]   processor_identity_straps_i,
	input  wire demand_type        demand_i,
	input  wire logic [7:0]        peer_request_lines_n_i,
	output logic      [7:0]        peer_request_lines_n_o,
	output logic      [7:0]        peer_request_lines_oe_o,
	input  wire logic              back_off_input_n_i,
	input  wire logic              host_request_input_n_i,
	input  wire logic              host_grant_line_n_i,
	output logic                   host_grant_line_n_o,
	output logic                   host_grant_line_oe_o,
	input  wire logic              master_indicator_n_i,
	output logic                   master_indicator_n_o,
	output logic                   master_indicator_oe_o,
	input  wire logic              lock_indicator_n_i,
	output logic                   lock_indicator_n_o,
	output logic                   lock_indicator_oe_o,
	input  wire logic              core_priority_line_n_i,
	output logic                   core_priority_line_n_o,
	output logic                   core_priority_line_oe_o,
	input  wire logic              dma_priority_line_n_i,
	output logic                   dma_priority_line_n_o,
	output logic                   dma_priority_line_oe_o,
	output busctl_type             busctl_o,
	output logic [1:0]             strap_o
);
	// ****************************************************************
	// strap capture
	// ****************************************************************
	// first enabled edge after release catches id and straps, since an
	// async reset may only load constants
	logic [ID_W-1:0] id_ff;
	logic            strap_done_ff;
	logic [1:0]      strap_ff;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			id_ff         <= ID_ZERO;
			strap_done_ff <= 1'b0;
			strap_ff      <= 2'h0;
		end else if (clk_en_i && !strap_done_ff) begin
			id_ff         <= processor_identity_straps_i;      // [R3] [R4]
			strap_ff      <= {master_indicator_n_i, lock_indicator_n_i}; // [R7]
			strap_done_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// decode of shared lines
	// ****************************************************************
	// absent peers float high, so they never look like requesters
	wire [7:0] peer_req   = ~peer_request_lines_n_i;              // [R1] [R5]
	wire [7:0] own_onehot = 8'(8'h01 << id_ff);                   // [R2]
	wire [7:0] other_req  = peer_req & ~own_onehot;
	wire       host_req   = ~host_request_input_n_i;
	wire       back_off   = ~back_off_input_n_i;
	// own drive is masked out so we only see slaves on the shared lines
	wire       cpa_other  = ~core_priority_line_n_i & ~core_priority_line_oe_o;
	wire       dpa_other  = ~dma_priority_line_n_i & ~dma_priority_line_oe_o;
	wire       local_want = demand_i.core_req | demand_i.dma_req | demand_i.hp_dma_req;
	wire       only_dma   = demand_i.dma_req & ~demand_i.core_req & ~demand_i.hp_dma_req;

	// ****************************************************************
	// arbitration
	// ****************************************************************
	own_state_type   state_ff;
	own_state_type   nxt_state;
	logic [ID_W-1:0] last_ff;
	logic [3:0]      cnt_ff;
	logic [3:0]      nxt_cnt;
	logic [ID_W-1:0] win;
	logic            any_req;
	logic            nxt_req_ln;
	wire  [7:0]      all_req = other_req | (own_onehot & {8{nxt_req_ln}});

	arb_prio #(
		.N (NUM_PROC)
	) u_prio (
		.req_i  (all_req),
		.last_i (last_ff),
		.win_o  (win),
		.any_o  (any_req)
	);

	// yield decisions while we own the bus
	wire yield_cpa  = cpa_other & ~demand_i.lock_req;             // [R18]
	wire yield_dpa  = dpa_other & only_dma & ~demand_i.lock_req;  // [R20]
	wire yield_peer = (other_req != 8'h00) & ~local_want & ~demand_i.lock_req;
	wire done_xact  = ~demand_i.xact_busy;
	wire release_ok = done_xact & (yield_cpa | yield_dpa | yield_peer);
	wire win_me     = any_req & (win == id_ff);                   // [R21]
	// another master is idle only when no other line is low and host is off
	wire bus_free   = (other_req == 8'h00) & host_grant_line_n_i;  // [R16]

	assign nxt_req_ln = local_want & strap_done_ff;

	// next-state selection
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (nxt_req_ln) begin
					nxt_state = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!local_want) begin
					nxt_state = ST_IDLE;
				// no re-grab while back-off still holds us off the bus
				end else if (win_me && bus_free && !host_req && !back_off) begin // [R10]
					nxt_state = ST_OWN;
				end
			end
			ST_OWN: begin
				if (back_off) begin
					nxt_state = ST_REQ;                       // [R10]
				end else if (host_req && done_xact) begin
					nxt_state = ST_SREF;                      // [R12]
					nxt_cnt   = SREF_CNT;
				end else if (!demand_i.lock_req && (release_ok || !local_want)) begin // [R8]
					nxt_state = local_want ? ST_REQ : ST_IDLE;
				end
			end
			ST_SREF: begin
				if (cnt_ff == CNT_ONE) begin
					nxt_state = ST_HOST;                      // [R14]
				end
				nxt_cnt = cnt_ff - CNT_ONE;
			end
			ST_HOST: begin
				if (!host_req) begin
					nxt_state = ST_IDLE;                      // [R15]
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state and round robin pointer
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= CNT_ZERO;
			last_ff  <= ID_ZERO;
		end else if (clk_en_i) begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			if (any_req) begin
				last_ff <= win;                               // [R21]
			end
		end
	end

	// ****************************************************************
	// pin and control outputs
	// ****************************************************************
	wire owner      = (state_ff == ST_OWN);
	wire host_phase = (nxt_state == ST_HOST);
	wire master_ish = (nxt_state == ST_OWN) | (nxt_state == ST_SREF) | host_phase;
	wire req_pin    = (nxt_state == ST_REQ) | (nxt_state == ST_OWN) | (nxt_state == ST_SREF);
	// open drain: priority pins low whenever their enable is high
	wire cpa_drive  = demand_i.core_req & (nxt_state == ST_OWN);  // [R17]
	wire dpa_drive  = demand_i.hp_dma_req & (nxt_state == ST_OWN); // [R19]
	busctl_type nxt_ctl;

	assign nxt_ctl.bus_drive   = (nxt_state == ST_OWN);           // [R13]
	assign nxt_ctl.dma_suspend = owner & (yield_cpa | yield_dpa);  // [R18] [R20]
	assign nxt_ctl.abort_xact  = owner & back_off;                // [R10]
	assign nxt_ctl.sref_req    = (nxt_state == ST_SREF) | host_phase; // [R14]

	// all outputs registered; while straps are sampled the pins stay undriven
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			peer_request_lines_n_o  <= LINES_IDLE;
			peer_request_lines_oe_o <= 8'h00;
			host_grant_line_n_o     <= 1'b1;
			host_grant_line_oe_o    <= 1'b0;
			master_indicator_n_o    <= 1'b1;
			master_indicator_oe_o   <= 1'b0;                  // [R7]
			lock_indicator_n_o      <= 1'b1;
			lock_indicator_oe_o     <= 1'b0;                  // [R7]
			core_priority_line_n_o  <= 1'b1;
			core_priority_line_oe_o <= 1'b0;
			dma_priority_line_n_o   <= 1'b1;
			dma_priority_line_oe_o  <= 1'b0;
			busctl_o                <= '0;
			strap_o                 <= 2'h0;
		end else if (clk_en_i && strap_done_ff) begin
			peer_request_lines_oe_o <= own_onehot;            // [R1] [R2]
			peer_request_lines_n_o  <= ~(own_onehot & {8{req_pin}});
			host_grant_line_oe_o    <= master_ish;            // [R16]
			host_grant_line_n_o     <= ~host_phase;           // [R12] [R15]
			master_indicator_oe_o   <= 1'b1;
			master_indicator_n_o    <= ~master_ish;           // [R6]
			lock_indicator_oe_o     <= 1'b1;
			lock_indicator_n_o      <= ~(demand_i.lock_req & (nxt_state == ST_OWN)); // [R8]
			core_priority_line_oe_o <= cpa_drive;
			core_priority_line_n_o  <= ~cpa_drive;
			dma_priority_line_oe_o  <= dpa_drive;
			dma_priority_line_n_o   <= ~dpa_drive;
			busctl_o                <= nxt_ctl;
			strap_o                 <= strap_ff;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	own_line_only_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		strap_done_ff |-> ((peer_request_lines_oe_o & ~own_onehot) == 8'h00)) // [R1]
		else $error("request line driven other than own");
	id_select_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(peer_request_lines_oe_o != 8'h00) |-> peer_request_lines_oe_o == own_onehot) // [R2]
		else $error("wrong request line for identity");
	straps_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!strap_done_ff |-> !master_indicator_oe_o && !lock_indicator_oe_o) // [R7]
		else $error("strap pins driven during capture");
	backoff_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(clk_en_i && owner && back_off) |=> !busctl_o.bus_drive && state_ff == ST_REQ) // [R10]
		else $error("bus kept after back-off");
	grant_after_sref_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$fell(host_grant_line_n_o) |-> $past(state_ff) == ST_SREF && busctl_o.sref_req) // [R14]
		else $error("host grant without self-refresh");
	grant_floats_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!host_grant_line_n_o |-> !busctl_o.bus_drive) // [R13]
		else $error("bus driven while host granted");
	grant_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(clk_en_i && state_ff == ST_HOST && host_req) |=> !host_grant_line_n_o) // [R15]
		else $error("grant dropped while host requests");
	cpa_core_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		core_priority_line_oe_o |-> master_indicator_oe_o && !master_indicator_n_o) // [R17]
		else $error("core priority driven off bus");
	lock_owner_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!lock_indicator_n_o |-> !master_indicator_n_o) // [R8]
		else $error("lock shown by non-owner");
	grant_master_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		host_grant_line_oe_o |-> !master_indicator_n_o) // [R16]
		else $error("slave drives host grant");

	own_bus_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		state_ff == ST_REQ ##1 state_ff == ST_OWN);
	host_hand_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		state_ff == ST_SREF ##[1:8] state_ff == ST_HOST);
	back_off_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		owner && back_off);
	cpa_yield_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		busctl_o.dma_suspend);
endmodule

// ==== src/arb_pkg.sv ====
// shared types and constants for the multiprocessor bus arbiter
// assumes a single 10 MHz system clock and active-low shared request lines
package arb_pkg;
	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int          NUM_PROC      = 8;
	localparam int          ID_W          = 3;
	localparam logic [2:0]  ID_ZERO       = 3'h0;
	localparam logic [7:0]  LINES_IDLE    = 8'hff;  // request lines idle high
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          SREF_TIME_NS  = 200;     // least self-refresh settle time
	localparam int          SREF_CYCLES   = (SREF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SREF_CNT      = 4'(SREF_CYCLES);
	localparam logic [3:0]  CNT_ZERO      = 4'h0;
	localparam logic [3:0]  CNT_ONE       = 4'h1;

	// ownership states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,  // slave, not requesting
		ST_REQ   = 3'b001,  // request asserted, waiting
		ST_OWN   = 3'b010,  // master of external bus
		ST_SREF  = 3'b011,  // entering sdram self-refresh for host
		ST_HOST  = 3'b100   // host owns the bus
	} own_state_type;

	// local demand from core and dma engines
	typedef struct packed {
		logic core_req;     // core wants an external access
		logic dma_req;      // normal-priority dma wants bus
		logic hp_dma_req;   // high-priority dma wants bus
		logic lock_req;     // locked sequence in progress
		logic xact_busy;    // a transaction is outstanding
	} demand_type;

	// bus control returned to the external port
	typedef struct packed {
		logic bus_drive;    // drive address, data, strobes, sdram pins
		logic dma_suspend;  // background dma must pause
		logic abort_xact;   // drop the outstanding transaction
		logic sref_req;     // put sdram into self-refresh
	} busctl_type;
endpackage

// ==== src/arb_prio.sv ====
// rotating priority picker over the eight request lines
// assumes the request vector is already active high and synchronous
`timescale 1ns/100ps
module arb_prio
	import arb_pkg::*;
#(
	parameter int N = NUM_PROC
) (
	input  wire logic [N-1:0]      req_i,
	input  wire logic [ID_W-1:0]   last_i,
	output logic      [ID_W-1:0]   win_o,
	output logic                   any_o
);
	// ****************************************************************
	// round robin search
	// ****************************************************************
	// search starts just after the last winner, so every id gets a turn
	logic [ID_W-1:0] cand [N];
	logic [N-1:0]    hit;
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_cand
			assign cand[g] = ID_W'(last_i + ID_W'(g + 1));
			assign hit[g]  = req_i[cand[g]];
		end
	endgenerate

	// lowest offset from the last winner wins
	always_comb begin
		win_o = last_i;
		for (int k = N - 1; k >= 0; k--) begin
			if (hit[k]) begin
				win_o = cand[k];
			end
		end
	end

	assign any_o = |req_i;
endmodule

// ==== test/peer_model.sv ====
// far-side model: peer processors and host on the shared lines
// assumes the bench wires its outputs and-ed with the arbiter drive
`timescale 1ns/100ps
module peer_model #(
	parameter logic [7:0] PRESENT = 8'hff
) (
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] peer_want_i,
	input  wire logic [3:0] host_want_i,
	output logic      [7:0] lines_n_o,
	output logic      [3:0] ctl_n_o
);
	// ****************************************************************
	// drive just after the falling edge
	// ****************************************************************
	// absent peers stay high, as the board pull-ups would hold them
	// ctl is {host request, back-off, core prio, dma prio}, held while wanted
	// grant is never driven here: the far side only watches it
	// combinational so the bench's falling-edge stimulus cannot race it
	assign lines_n_o = rst_n_i ? ~(peer_want_i & PRESENT) : 8'hff;
	assign ctl_n_o   = rst_n_i ? ~host_want_i : 4'hf;
endmodule

// ==== test/bus_arbiter_tb_top.sv ====
// self-checking bench for the bus arbiter
// assumes pull-ups on every shared line, resolved here from all enables
`timescale 1ns/100ps
module bus_arbiter_tb_top;
	import arb_pkg::*;
	logic            mclk_i   = 1'b0;
	logic            rst_n_i  = 1'b0;
	logic [ID_W-1:0] id_s     = 3'h0;
	demand_type      dm       = '0;
	logic [7:0]      want     = 8'h00;
	logic [3:0]      hw       = 4'h0;
	logic [1:0]      strap_v  = 2'h3;
	logic            strap_en = 1'b1;
	logic [31:0]     seed     = 32'h99874f9c;
	int              error_cnt   = 0;
	int              checks_done = 0;
	int              n;
	logic [7:0]      ml, rq_o, rq_oe;
	logic [3:0]      ctl;
	logic            gr_o, gr_oe, mi_o, mi_oe, lk_o, lk_oe, cp_o, cp_oe, dp_o, dp_oe;
	busctl_type      bc;
	logic [1:0]      st;
	// ****************************************************************
	// clock, wires and instances
	// ****************************************************************
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	// open-drain and three-state resolution, straps shown until captured after reset
	wire [7:0] rq_w = ml & (~rq_oe | rq_o);
	wire       gr_w = ~gr_oe | gr_o;
	wire       mi_w = strap_en ? strap_v[1] : (~mi_oe | mi_o);
	wire       lk_w = strap_en ? strap_v[0] : (~lk_oe | lk_o);
	wire       cp_w = ctl[1] & ~(cp_oe & ~cp_o);
	wire       dp_w = ctl[0] & ~(dp_oe & ~dp_o);
	peer_model #(.PRESENT(8'h7f)) far_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .peer_want_i(want),
		.host_want_i(hw), .lines_n_o(ml), .ctl_n_o(ctl));
	bus_arbiter dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
		.processor_identity_straps_i(id_s), .demand_i(dm), .peer_request_lines_n_i(rq_w),
		.peer_request_lines_n_o(rq_o), .peer_request_lines_oe_o(rq_oe), .back_off_input_n_i(ctl[2]),
		.host_request_input_n_i(ctl[3]), .host_grant_line_n_i(gr_w), .host_grant_line_n_o(gr_o),
		.host_grant_line_oe_o(gr_oe), .master_indicator_n_i(mi_w), .master_indicator_n_o(mi_o),
		.master_indicator_oe_o(mi_oe), .lock_indicator_n_i(lk_w), .lock_indicator_n_o(lk_o),
		.lock_indicator_oe_o(lk_oe), .core_priority_line_n_i(cp_w), .core_priority_line_n_o(cp_o),
		.core_priority_line_oe_o(cp_oe), .dma_priority_line_n_i(dp_w), .dma_priority_line_n_o(dp_o),
		.dma_priority_line_oe_o(dp_oe), .busctl_o(bc), .strap_o(st));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] xs();
		logic [31:0] s;
		s = seed;
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		seed = s;
		return s;
	endfunction
	// one-hot request enable expected for an identity
	function automatic logic [7:0] exp_oe(input logic [2:0] id);
		return 8'h01 << id;
	endfunction
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait on one output; a miss ends the run
	task automatic wt(input int sel, input logic lvl);
		logic v;
		for (int k = 0; k < 40; k++) begin
			@(negedge mclk_i);
			case (sel)
				0: v = mi_o;
				1: v = bc.bus_drive;
				2: v = bc.sref_req;
				3: v = gr_o;
				4: v = lk_o;
				default: v = bc.dma_suspend;
			endcase
			if (v === lvl) return;
		end
		chk(8'h00, 8'h01);
		print_verdict();
	endtask
	// reset with random straps; ids only change in here
	task automatic reset_to(input logic [2:0] id);
		@(negedge mclk_i);
		rst_n_i = 1'b0;
		dm = '0;
		want = 8'h00;
		hw = 4'h0;
		strap_en = 1'b1;
		strap_v = 2'(xs() >> 7);
		id_s = id;
		repeat (10) @(negedge mclk_i);
		chk({rq_oe[6:0], gr_oe}, 8'h00);
		chk({4'h0, mi_oe, lk_oe, cp_oe, dp_oe}, 8'h00);
		chk(8'(bc), 8'h00);
		rst_n_i = 1'b1;
		repeat (2) @(negedge mclk_i);
		chk(8'(st), 8'(strap_v));
		strap_en = 1'b0;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		// every identity, core and high-priority dma alternately
		for (int i = 0; i < 8; i++) begin
			reset_to(3'(i));
			if (i % 2 == 1) dm.hp_dma_req = 1'b1;
			else dm.core_req = 1'b1;
			wt(0, 1'b0);
			chk(rq_oe, exp_oe(3'(i)));
			chk(8'(rq_o[i]), 8'h00);
			chk(8'({mi_oe, bc.bus_drive}), 8'h03);
			chk(8'({cp_oe, cp_o, dp_oe, dp_o}), (i % 2 == 1) ? 8'h06 : 8'h09);
		end
		// host waits for a busy transaction, then self-refresh, then grant
		reset_to(3'(xs()));
		dm.core_req = 1'b1;
		dm.xact_busy = 1'b1;
		wt(0, 1'b0);
		hw = 4'h8;
		repeat (5) @(negedge mclk_i);
		chk(8'({bc.sref_req, bc.bus_drive}), 8'h01);
		dm.xact_busy = 1'b0;
		wt(2, 1'b1);
		chk(8'({bc.bus_drive, gr_oe}), 8'h01);
		n = 0;
		while (gr_o !== 1'b0 && n < 20) begin
			@(negedge mclk_i);
			n++;
		end
		chk(8'(n), 8'(SREF_CYCLES));
		repeat (3) @(negedge mclk_i);
		chk(8'({gr_oe, gr_o}), 8'h02);
		hw = 4'h0;
		repeat (2) @(negedge mclk_i);
		chk(8'({gr_oe, gr_o}), 8'h01);
		// back-off in mid-transaction drops it at once
		reset_to(3'(xs()));
		dm.core_req = 1'b1;
		dm.xact_busy = 1'b1;
		wt(0, 1'b0);
		hw = 4'h4;
		@(negedge mclk_i);
		chk(8'({bc.abort_xact, bc.bus_drive}), 8'h02);
		repeat (2) @(negedge mclk_i);
		chk(8'({bc.abort_xact, bc.bus_drive}), 8'h00);
		// lock holds the bus against a peer until dropped
		reset_to(3'h1);
		dm.core_req = 1'b1;
		dm.lock_req = 1'b1;
		wt(0, 1'b0);
		wt(4, 1'b0);
		chk(8'(lk_oe), 8'h01);
		dm.core_req = 1'b0;
		want = 8'(xs()) | 8'h04;
		want[1] = 1'b0;
		repeat (6) @(negedge mclk_i);
		chk(8'(mi_o), 8'h00);
		dm.lock_req = 1'b0;
		wt(0, 1'b1);
		// slave core and dma priority pre-empt background dma
		for (int k = 0; k < 2; k++) begin
			reset_to(3'(xs()));
			dm.dma_req = 1'b1;
			wt(0, 1'b0);
			hw = (k == 0) ? 4'h2 : 4'h1;
			wt(5, 1'b1);
		end
		print_verdict();
	end
endmodule
